// ---- oag_core.sv ----
`timescale 1ns/10ps
`default_nettype none

// Operation
// - Short forms except short indexed and indirect indexed stay in page zero; memory-to-memory ops accept short forms and inherent only.
// - Inherent: opcode only, no operand or address bytes fetched.
// - Immediate: one byte follows, used as operand without memory access.
// - Short direct: one address byte, range 00 to FF.
// - Long direct: two-byte address word, full 64 Kbyte space.
// - Indexed address is unsigned sum of X or Y and the offset.
// - Indexed without offset: no byte fetched, index alone is the address.
// - Short indexed: one offset byte plus index, carry kept, up to 1FE.
// - Long indexed: two-byte offset word plus index, full space.
// - Indirect: one pointer address byte, pointer read from page zero.
// - Short indirect: byte pointer read is the address, range 00 to FF.
// - Long indirect: word pointer read from page zero, full space.
// - Indirect indexed: pointer plus index, byte to 1FE, word full space.
module oag_core (
  input wire logic clock,
  input wire logic arst_n,
  input wire logic start,
  input wire oag_pkg::oag_req_type req,
  input wire logic [7:0] idx_x,
  input wire logic [7:0] idx_y,
  output logic busy,
  output logic fetch_req,
  input wire logic fetch_valid,
  input wire logic [7:0] fetch_data,
  output logic mem_req,
  output logic [15:0] mem_addr,
  input wire logic mem_valid,
  input wire logic [7:0] mem_data,
  output logic done,
  output oag_pkg::oag_res_type res
);

  ////////////////////////////////////////////////////////////////////////
  typedef enum logic [2:0] {
    OAG_S_IDLE = 3'b000,
    OAG_S_FB0  = 3'b001,
    OAG_S_FB1  = 3'b011,
    OAG_S_PR0  = 3'b010,
    OAG_S_PR1  = 3'b110,
    OAG_S_DONE = 3'b111
  } oag_state_type;

  function automatic logic is_short(input oag_pkg::oag_mode_type m);
    is_short = (m == oag_pkg::OAG_MODE_DIR_S) || (m == oag_pkg::OAG_MODE_IDX_0) ||
               (m == oag_pkg::OAG_MODE_IDX_S) || (m == oag_pkg::OAG_MODE_IND_S) ||
               (m == oag_pkg::OAG_MODE_INDIDX_S);
  endfunction

  function automatic logic is_indirect(input oag_pkg::oag_mode_type m);
    is_indirect = (m == oag_pkg::OAG_MODE_IND_S) || (m == oag_pkg::OAG_MODE_IND_L) ||
                  (m == oag_pkg::OAG_MODE_INDIDX_S) || (m == oag_pkg::OAG_MODE_INDIDX_L);
  endfunction

  function automatic logic is_word(input oag_pkg::oag_mode_type m);
    is_word = (m == oag_pkg::OAG_MODE_DIR_L) || (m == oag_pkg::OAG_MODE_IDX_L) ||
              (m == oag_pkg::OAG_MODE_IND_L) || (m == oag_pkg::OAG_MODE_INDIDX_L);
  endfunction

  function automatic logic is_indexed(input oag_pkg::oag_mode_type m);
    is_indexed = (m == oag_pkg::OAG_MODE_IDX_0) || (m == oag_pkg::OAG_MODE_IDX_S) ||
                 (m == oag_pkg::OAG_MODE_IDX_L) || (m == oag_pkg::OAG_MODE_INDIDX_S) ||
                 (m == oag_pkg::OAG_MODE_INDIDX_L);
  endfunction

  ////////////////////////////////////////////////////////////////////////
  logic rst_s1_r;
  logic rst_s2_r;
  logic rst_n;

  // Reset release passes two stages so all state leaves reset on the same edge
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      rst_s1_r <= 1'b0;
      rst_s2_r <= 1'b0;
    end else begin
      rst_s1_r <= 1'b1;
      rst_s2_r <= rst_s1_r;
    end
  end
  assign rst_n = rst_s2_r;

  ////////////////////////////////////////////////////////////////////////
  oag_state_type state_r, state_nxt;
  oag_pkg::oag_mode_type mode_r, mode_nxt;
  logic [7:0] index_r, index_nxt;
  logic [15:0] word_r, word_nxt;
  logic [1:0] len_r, len_nxt;
  logic illegal_r, illegal_nxt;
  oag_pkg::oag_res_type res_r, res_nxt;
  logic done_r, done_nxt;
  logic [15:0] sum;
  logic [15:0] base;

  // Index of zero for unindexed modes keeps one adder on every path
  assign base = word_r;

  oag_addr_add u_add (
    .base(base),
    .index(index_r),
    .sum(sum)
  );

  always_comb begin
    state_nxt = state_r;
    mode_nxt = mode_r;
    index_nxt = index_r;
    word_nxt = word_r;
    len_nxt = len_r;
    illegal_nxt = illegal_r;
    res_nxt = res_r;
    done_nxt = 1'b0;
    case (state_r)
      OAG_S_IDLE: begin
        if (start) begin
          mode_nxt = req.mode;
          index_nxt = is_indexed(req.mode) ? (req.use_y ? idx_y : idx_x) : oag_pkg::OAG_RST_BYTE;
          word_nxt = oag_pkg::OAG_RST_ADDR;
          illegal_nxt = req.mem_to_mem && !is_short(req.mode) && (req.mode != oag_pkg::OAG_MODE_INH);
          if (req.mode == oag_pkg::OAG_MODE_INH || req.mode == oag_pkg::OAG_MODE_IDX_0) begin
            len_nxt = oag_pkg::OAG_LEN_0;
            state_nxt = OAG_S_DONE;
          end else if (is_word(req.mode) && !is_indirect(req.mode)) begin
            len_nxt = oag_pkg::OAG_LEN_2;
            state_nxt = OAG_S_FB0;
          end else begin
            len_nxt = oag_pkg::OAG_LEN_1;
            state_nxt = OAG_S_FB1;
          end
        end
      end
      OAG_S_FB0: begin
        if (fetch_valid) begin
          word_nxt = {fetch_data, oag_pkg::OAG_RST_BYTE};
          state_nxt = OAG_S_FB1;
        end
      end
      OAG_S_FB1: begin
        if (fetch_valid) begin
          word_nxt = {word_r[15:8], fetch_data};
          if (is_indirect(mode_r)) begin
            state_nxt = is_word(mode_r) ? OAG_S_PR0 : OAG_S_PR1;
          end else begin
            state_nxt = OAG_S_DONE;
          end
        end
      end
      OAG_S_PR0: begin
        if (mem_valid) begin
          word_nxt = {mem_data, word_r[7:0]};
          state_nxt = OAG_S_PR1;
        end
      end
      OAG_S_PR1: begin
        if (mem_valid) begin
          if (is_word(mode_r)) begin
            word_nxt = {word_r[15:8], mem_data};
          end else begin
            word_nxt = {8'h00, mem_data};
          end
          state_nxt = OAG_S_DONE;
        end
      end
      OAG_S_DONE: begin
        res_nxt.addr = sum;
        res_nxt.imm = word_r[7:0];
        res_nxt.is_imm = (mode_r == oag_pkg::OAG_MODE_IMM);
        res_nxt.no_operand = (mode_r == oag_pkg::OAG_MODE_INH);
        res_nxt.length = len_r;
        res_nxt.illegal = illegal_r;
        if (mode_r == oag_pkg::OAG_MODE_INH || mode_r == oag_pkg::OAG_MODE_IMM) begin
          res_nxt.addr = oag_pkg::OAG_RST_ADDR;
        end
        done_nxt = 1'b1;
        state_nxt = OAG_S_IDLE;
      end
      default: begin
        state_nxt = OAG_S_IDLE;
      end
    endcase
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= OAG_S_IDLE;
      mode_r <= oag_pkg::OAG_MODE_INH;
      index_r <= oag_pkg::OAG_RST_BYTE;
      word_r <= oag_pkg::OAG_RST_ADDR;
      len_r <= oag_pkg::OAG_LEN_0;
      illegal_r <= 1'b0;
      res_r <= '0;
      done_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      mode_r <= mode_nxt;
      index_r <= index_nxt;
      word_r <= word_nxt;
      len_r <= len_nxt;
      illegal_r <= illegal_nxt;
      res_r <= res_nxt;
      done_r <= done_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Pointer location is always page zero; a word pointer's second byte wraps inside it
  assign busy = (state_r != OAG_S_IDLE);
  assign fetch_req = (state_r == OAG_S_FB0) || (state_r == OAG_S_FB1);
  assign mem_req = (state_r == OAG_S_PR0) || (state_r == OAG_S_PR1);
  assign mem_addr = (state_r == OAG_S_PR1 && is_word(mode_r)) ?
                    ((word_r & oag_pkg::OAG_PAGE0_MASK) + 16'h0001) & oag_pkg::OAG_PAGE0_MASK :
                    word_r & oag_pkg::OAG_PAGE0_MASK;
  assign done = done_r;
  assign res = res_r;

endmodule

`default_nettype wire

// ---- oag_pkg.sv ----
`default_nettype none
package oag_pkg;

  typedef enum logic [3:0] {
    OAG_MODE_INH      = 4'h0,
    OAG_MODE_IMM      = 4'h1,
    OAG_MODE_DIR_S    = 4'h2,
    OAG_MODE_DIR_L    = 4'h3,
    OAG_MODE_IDX_0    = 4'h4,
    OAG_MODE_IDX_S    = 4'h5,
    OAG_MODE_IDX_L    = 4'h6,
    OAG_MODE_IND_S    = 4'h7,
    OAG_MODE_IND_L    = 4'h8,
    OAG_MODE_INDIDX_S = 4'h9,
    OAG_MODE_INDIDX_L = 4'hA
  } oag_mode_type;

  typedef struct packed {
    oag_mode_type mode;
    logic         use_y;
    logic         mem_to_mem;
  } oag_req_type;

  typedef struct packed {
    logic [15:0] addr;
    logic [7:0]  imm;
    logic        is_imm;
    logic        no_operand;
    logic [1:0]  length;
    logic        illegal;
  } oag_res_type;

  localparam logic [15:0] OAG_PAGE0_MASK = 16'h00FF;
  localparam logic [1:0] OAG_LEN_0 = 2'h0;
  localparam logic [1:0] OAG_LEN_1 = 2'h1;
  localparam logic [1:0] OAG_LEN_2 = 2'h2;
  localparam logic [7:0] OAG_RST_BYTE = 8'h00;
  localparam logic [15:0] OAG_RST_ADDR = 16'h0000;

endpackage

`default_nettype wire

// ---- oag_addr_add.sv ----
`timescale 1ns/10ps
`default_nettype none

// Unsigned base plus index; carry runs into the high byte, no page wrap
module oag_addr_add (
  input wire logic [15:0] base,
  input wire logic [7:0] index,
  output logic [15:0] sum
);
  assign sum = base + {8'h00, index};
endmodule

`default_nettype wire

// ---- oag_core_checker.sv ----
`timescale 1ns/10ps
`default_nettype none
module oag_core_checker (
  input wire logic clock,
  input wire logic arst_n,
  input wire logic start,
  input wire oag_pkg::oag_req_type req,
  input wire logic busy,
  input wire logic fetch_req,
  input wire logic fetch_valid,
  input wire logic mem_req,
  input wire logic [15:0] mem_addr,
  input wire logic mem_valid,
  input wire logic done,
  input wire oag_pkg::oag_res_type res
);
  default clocking @(posedge clock); endclocking
  default disable iff (!arst_n);
  logic take;
  assign take = start && !busy;
  ////////////////////////////////////////////////////////////////
  chk_inherent_no_fetch:
    assert property (take && req.mode == oag_pkg::OAG_MODE_INH |-> ##1 !fetch_req && !mem_req
      ##1 done && res.length == oag_pkg::OAG_LEN_0 && res.no_operand) else $error("inherent result wrong");
  chk_noofs_page0:
    assert property (take && req.mode == oag_pkg::OAG_MODE_IDX_0 |-> ##1 !fetch_req
      ##1 done && res.addr[15:8] == 8'h00 && res.length == oag_pkg::OAG_LEN_0) else $error("no-offset wrong");
  chk_imm_length:
    assert property (done && res.is_imm |-> res.length == oag_pkg::OAG_LEN_1 && res.addr == 16'h0000)
      else $error("immediate result wrong");
  chk_ptr_page0:
    assert property (mem_req |-> mem_addr[15:8] == 8'h00) else $error("pointer read off page zero");
  chk_ptr_hold:
    assert property (mem_req && !mem_valid |=> mem_req && $stable(mem_addr)) else $error("pointer read dropped");
  chk_ptr_next:
    assert property (mem_req && mem_valid |=> !mem_req || mem_addr == {8'h00, $past(mem_addr[7:0]) + 8'h01})
      else $error("second pointer byte misplaced");
  chk_fetch_hold:
    assert property (fetch_req && !fetch_valid |=> fetch_req) else $error("fetch request dropped");
  chk_idle_quiet:
    assert property (!busy |-> !fetch_req && !mem_req) else $error("request while idle");
  chk_done_pulse:
    assert property (done |=> !done) else $error("done longer than one cycle");
endmodule
bind oag_core oag_core_checker chk_i (.clock(clock), .arst_n(arst_n), .start(start), .req(req), .busy(busy),
  .fetch_req(fetch_req), .fetch_valid(fetch_valid), .mem_req(mem_req), .mem_addr(mem_addr),
  .mem_valid(mem_valid), .done(done), .res(res));
`default_nettype wire

// ---- oag_core_tb.sv ----
`timescale 1ns/10ps
`default_nettype none
module oag_core_tb;
  logic clock = 1'b0;
  logic arst_n = 1'b0;
  logic start = 1'b0;
  logic fetch_valid = 1'b0;
  logic mem_valid = 1'b0;
  logic [7:0] idx_x = 8'h00;
  logic [7:0] idx_y = 8'h00;
  logic [7:0] fetch_data = 8'h00;
  logic [7:0] mem_data = 8'h00;
  oag_pkg::oag_req_type req = '0;
  logic busy, fetch_req, mem_req, done;
  logic [15:0] mem_addr;
  oag_pkg::oag_res_type res;
  int bad_count = 0;
  int total_checks = 0;
  always #4 clock = ~clock;
  oag_core uut (.clock(clock), .arst_n(arst_n), .start(start), .req(req), .idx_x(idx_x), .idx_y(idx_y),
    .busy(busy), .fetch_req(fetch_req), .fetch_valid(fetch_valid), .fetch_data(fetch_data),
    .mem_req(mem_req), .mem_addr(mem_addr), .mem_valid(mem_valid), .mem_data(mem_data), .done(done), .res(res));
  ////////////////////////////////////////////////////////////////
  task automatic stop_test;
    $display("Checks %0d, mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // Unused index gets the inverse, so a wrong X/Y pick shows up; memory byte at a is a^C3
  task automatic run(input logic [3:0] m, input logic uy, input logic mm, input logic [7:0] ix,
    input logic [15:0] wd, input int st, input logic [15:0] ea, input logic [1:0] len, input logic [1:0] rd,
    input logic ill);
    int n;
    int w;
    int k;
    int r;
    req = '{oag_pkg::oag_mode_type'(m), uy, mm};
    idx_x = uy ? ~ix : ix;
    idx_y = uy ? ix : ~ix;
    start = 1'b1;
    w = 0;
    k = 0;
    r = 0;
    @(posedge clock);
    #1 start = 1'b0;
    chk(16'({busy, fetch_req}), {14'h0000, 1'b1, len != 2'h0});
    for (n = 0; n < 40 && done !== 1'b1; n++) begin
      fetch_valid = fetch_req === 1'b1 && w >= st;
      fetch_data = fetch_valid ? (k == 0 ? wd[15:8] : wd[7:0]) : ~fetch_data;
      mem_valid = mem_req === 1'b1 && w >= st;
      mem_data = mem_valid ? mem_addr[7:0] ^ 8'hC3 : ~mem_data;
      if (fetch_valid || mem_valid) w = 0;
      else if (fetch_req || mem_req) w++;
      @(posedge clock);
      #1;
      k += int'(fetch_valid);
      r += int'(mem_valid);
    end
    fetch_valid = 1'b0;
    mem_valid = 1'b0;
    if (n == 40) begin
      bad_count++;
      stop_test();
    end
    chk(res.addr, ea);
    chk(16'(k), 16'(len));
    chk(16'(r), 16'(rd));
    chk(16'(res.length), 16'(len));
    chk(16'(res.illegal), 16'(ill));
    chk(16'(res.is_imm), 16'(m == 4'h1));
    chk(16'({busy, res.no_operand}), 16'(m == 4'h0));
  endtask
  ////////////////////////////////////////////////////////////////
  task automatic sc_short;
    run(4'h0, 1'b0, 1'b0, 8'h11, 16'h0000, 0, 16'h0000, 2'h0, 2'h0, 1'b0);
    run(4'h1, 1'b0, 1'b0, 8'h11, 16'h5500, 0, 16'h0000, 2'h1, 2'h0, 1'b0);
    chk(16'(res.imm), 16'h0055);
    run(4'h2, 1'b0, 1'b0, 8'h11, 16'hFF00, 2, 16'h00FF, 2'h1, 2'h0, 1'b0);
    run(4'h4, 1'b1, 1'b0, 8'hFF, 16'h0000, 0, 16'h00FF, 2'h0, 2'h0, 1'b0);
    run(4'h5, 1'b0, 1'b0, 8'hFF, 16'hFF00, 0, 16'h01FE, 2'h1, 2'h0, 1'b0);
  endtask
  task automatic sc_long;
    run(4'h3, 1'b0, 1'b0, 8'h11, 16'h1234, 3, 16'h1234, 2'h2, 2'h0, 1'b0);
    run(4'h6, 1'b1, 1'b0, 8'h20, 16'hFEF0, 2, 16'hFF10, 2'h2, 2'h0, 1'b0);
  endtask
  // Pointer FF checks the second byte wraps to 00 instead of leaving page zero
  task automatic sc_indirect;
    run(4'h7, 1'b0, 1'b0, 8'h11, 16'h1000, 0, 16'h00D3, 2'h1, 2'h1, 1'b0);
    run(4'h8, 1'b0, 1'b0, 8'h11, 16'hFF00, 1, 16'h3CC3, 2'h1, 2'h2, 1'b0);
    run(4'h9, 1'b1, 1'b0, 8'hFF, 16'h3C00, 0, 16'h01FE, 2'h1, 2'h1, 1'b0);
    run(4'hA, 1'b0, 1'b0, 8'h40, 16'h2000, 2, 16'hE422, 2'h1, 2'h2, 1'b0);
  endtask
  task automatic sc_mem_ops;
    run(4'h3, 1'b0, 1'b1, 8'h11, 16'h1234, 0, 16'h1234, 2'h2, 2'h0, 1'b1);
    run(4'h5, 1'b0, 1'b1, 8'h01, 16'h8000, 0, 16'h0081, 2'h1, 2'h0, 1'b0);
  endtask
  ////////////////////////////////////////////////////////////////
  initial begin
    repeat (12) @(posedge clock);
    #1 arst_n = 1'b1;
    repeat (3) @(posedge clock);
    #1;
    sc_short();
    sc_long();
    sc_indirect();
    sc_mem_ops();
    stop_test();
  end
endmodule
`default_nettype wire
